// ==== hdl/imc_defines.svh ====
// Offsets, field positions, codes, reset values and timing for the IMU control block
`ifndef IMC_DEFINES_SVH
`define IMC_DEFINES_SVH

// Accelerometer register offsets
`define IMC_ACC_ID_ADDR 8'h00
`define IMC_ACC_DATA_ADDR 8'h12
`define IMC_ACC_TIME_ADDR 8'h18
`define IMC_ACC_TEMP_ADDR 8'h22
`define IMC_ACCEL_CONFIG_ADDR 8'h40
`define IMC_ACC_PWR_ADDR 8'h7D
`define IMC_ACC_SRST_ADDR 8'h7E

// Gyroscope register offsets
`define IMC_GYR_ID_ADDR 8'h00
`define IMC_GYR_DATA_ADDR 8'h02
`define IMC_GYR_CONF_ADDR 8'h0F
`define IMC_GYR_LPM_ADDR 8'h11
`define IMC_GYR_SRST_ADDR 8'h14

// Block sizes in bytes
`define IMC_DATA_BYTES 8'h06
`define IMC_TIME_BYTES 8'h03

// Command and mode codes
`define IMC_ACC_PWR_ON 8'h04
`define IMC_ACC_PWR_OFF 8'h00
`define IMC_GYR_LPM_NORMAL 8'h00
`define IMC_GYR_LPM_SUSPEND 8'h80
`define IMC_GYR_LPM_DEEP 8'h20
`define IMC_SOFT_RESET_CMD 8'hB6
`define IMC_BWP_NORMAL 4'hA
`define IMC_BWP_OSR2 4'h9
`define IMC_BWP_OSR4 4'h8
`define IMC_ODR_MIN 4'h5
`define IMC_ODR_MAX 4'hC

// Field positions in the accel config register
`define IMC_CONF_BWP_MSB 7
`define IMC_CONF_BWP_LSB 4
`define IMC_CONF_ODR_MSB 3
`define IMC_CONF_ODR_LSB 0

// Reset values
`define IMC_ACCEL_CONFIG_RST 8'hA8
`define IMC_GYR_CONF_RST 8'h00

// Timing
`define IMC_CLK_NS 100
`define IMC_CLK_PS (`IMC_CLK_NS * 1000)
`define IMC_ACC_BOOT_NS 1000000
`define IMC_GYR_SETTLE_NS 30000000
`define IMC_TIME_TICK_PS 39062500

`endif

// ==== hdl/imc_pkg.sv ====
// Types shared by the IMU control block
package imc_pkg;

	typedef enum logic [1:0] {IMC_GYR_NORMAL, IMC_GYR_SUSPEND, IMC_GYR_DEEP} imc_gyro_mode_t;

	typedef enum logic [1:0] {IMC_FILT_NORMAL, IMC_FILT_OSR2, IMC_FILT_OSR4} imc_filter_t;

	// One register access from the serial front end
	typedef struct packed {
		logic wr;
		logic rd;
		logic burst;
		logic [7:0] addr;
		logic [7:0] wdata;
	} imc_req_t;

	typedef struct packed {
		logic valid;
		logic [2:0][15:0] axis;
	} imc_sample_t;

	typedef struct packed {
		logic valid;
		logic [10:0] value;
	} imc_temp_t;

	typedef struct packed {
		logic [25:0] acc;
		logic [23:0] count;
	} imc_time_t;

	typedef struct packed {
		logic cs_meta;
		logic cs_sync;
		logic cs_prev;
		logic ps_meta;
		logic ps_sync;
		logic [1:0] ps_wait;
		logic ps_taken;
		logic acc_spi;
		logic gyr_spi;
		logic [7:0] acc_pwr;
		logic [7:0] accel_config;
		logic [19:0] acc_boot;
		logic acc_en;
		logic acc_busy;
		imc_filter_t acc_filt;
		logic acc_burst;
		logic [7:0] acc_ptr;
		logic [2:0][15:0] acc_img;
		logic [10:0] tmp_img;
		logic [23:0] time_img;
		logic [3:0][7:0] acc_shadow;
		logic [7:0] acc_rdata;
		logic acc_rvalid;
		imc_gyro_mode_t gyr_mode;
		logic [7:0] gyr_conf;
		logic [19:0] gyr_settle;
		logic gyr_busy;
		logic gyr_on;
		logic gyr_burst;
		logic [7:0] gyr_ptr;
		logic [2:0][15:0] gyr_img;
		logic [2:0][7:0] gyr_shadow;
		logic [7:0] gyr_rdata;
		logic gyr_rvalid;
	} imc_state_t;

endpackage

// ==== hdl/imc_sensor_time.sv ====
// Free-running 24-bit sensor time counter
`timescale 1ns/1ns
`include "imc_defines.svh"

module imc_sensor_time import imc_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Count
	output logic [23:0] count
);

	imc_time_t s;
	imc_time_t n;

	// Tick period is not a whole number of cycles, so carry the remainder in picoseconds
	always_comb begin
		n = s;
		n.acc = s.acc + 26'(`IMC_CLK_PS);
		if (n.acc >= 26'(`IMC_TIME_TICK_PS)) begin
			n.acc = n.acc - 26'(`IMC_TIME_TICK_PS);
			n.count = s.count + 24'h000001;
		end
		if (!rstn) begin
			n = '0;
		end
	end

	always_ff @(posedge clk) begin
		s <= n;
	end

	assign count = s.count;

endmodule

// ==== hdl/imc_top.sv ====
// Power-mode, interface-select and data readout control of the IMU
//
// Behaviour
// - Accel interface starts I2C; first chip-select rising edge selects SPI until reset.
// - Gyro interface follows the select pin level, taken again at every reset.
// - After reset gyro is in normal mode, accel is in suspend.
// - Accel power 0x04 gives normal mode; 0x00 gives suspend.
// - Accel power register gates measurement and temperature sensor together.
// - Accel boots within 1 ms after reset or soft reset.
// - Gyro low-power 0x80 enters suspend; 0x00 or soft reset leaves it.
// - Gyro suspend stops acquisition, keeps data and config, registers stay readable.
// - Gyro low-power 0x20 enters deep suspend; 0x00 or soft reset leaves it.
// - Deep suspend keeps the interface and data, stops acquisition, loses configuration.
// - Gyro reaches a new power state within 30 ms after reset or change.
// - Reset clears logic, registers and interface.
// - Axis samples are 16 bits, temperature 11 bits, split in low and high bytes.
// - Reading a low byte locks the matching high byte in a shadow.
// - Burst reads advance the read address by one per byte.
// - During a burst the part's data registers are frozen.
// - Accel holds a free-running 24-bit time counter ticking every 39.0625 us.
// - Bandwidth field 0xA normal, 0x9 two-times, 0x8 four-times oversampling.
// - Accel config holds output rate and oversampling, 12.5 Hz to 1600 Hz.
`timescale 1ns/1ns
`include "imc_defines.svh"

module imc_top import imc_pkg::*; #(
	parameter int ACC_BOOT_CYCLES = `IMC_ACC_BOOT_NS / `IMC_CLK_NS,
	parameter int GYR_SETTLE_CYCLES = `IMC_GYR_SETTLE_NS / `IMC_CLK_NS,
	// Identification values are arbitrary
	parameter logic [7:0] ACC_ID = 8'h5A,
	parameter logic [7:0] GYR_ID = 8'h3C
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Pins
	input wire logic interface_select_pin,
	input wire logic accel_chip_select,
	// Accel register access
	input wire imc_req_t acc_req,
	output logic [7:0] acc_rdata,
	output logic acc_rvalid,
	// Gyro register access
	input wire imc_req_t gyr_req,
	output logic [7:0] gyr_rdata,
	output logic gyr_rvalid,
	// Front-end samples
	input wire imc_sample_t acc_sample,
	input wire imc_temp_t temp_sample,
	input wire imc_sample_t gyr_sample,
	// Interface selection
	output logic accel_spi_mode,
	output logic gyro_spi_mode,
	// Accel control
	output logic accel_enable,
	output logic accel_booting,
	output imc_filter_t accel_filter,
	output logic [3:0] accel_output_rate,
	output logic [23:0] sensor_time,
	// Gyro control
	output imc_gyro_mode_t gyro_mode,
	output logic gyro_settling,
	output logic gyro_analog_on,
	output logic [7:0] gyro_config
);

	imc_state_t s;
	imc_state_t n;
	logic [7:0] a_eff;
	logic [7:0] a_off;
	logic [7:0] g_eff;
	logic [7:0] g_off;
	logic a_frz;
	logic g_frz;
	logic [23:0] time_count;

	imc_sensor_time u_time (
		.clk(clk),
		.rstn(rstn),
		.count(time_count)
	);

	function automatic logic in_block(input logic [7:0] a, input logic [7:0] base, input logic [7:0] len);
		in_block = (a >= base) && (a < base + len);
	endfunction

	// Low byte from the live image, high byte from the shadow
	function automatic logic [7:0] data_byte(input logic [2:0][15:0] img, input logic [2:0][7:0] sh,
		input logic [7:0] off);
		if (off[0]) begin
			data_byte = sh[off[2:1]];
		end else begin
			data_byte = img[off[2:1]][7:0];
		end
	endfunction

	function automatic imc_filter_t filt_of(input logic [3:0] bwp);
		if (bwp == `IMC_BWP_OSR2) begin
			filt_of = IMC_FILT_OSR2;
		end else if (bwp == `IMC_BWP_OSR4) begin
			filt_of = IMC_FILT_OSR4;
		end else begin
			filt_of = IMC_FILT_NORMAL;
		end
	endfunction

	function automatic logic conf_ok(input logic [7:0] v);
		logic [3:0] bwp;
		logic [3:0] output_rate;
		bwp = v[`IMC_CONF_BWP_MSB:`IMC_CONF_BWP_LSB];
		output_rate = v[`IMC_CONF_ODR_MSB:`IMC_CONF_ODR_LSB];
		conf_ok = (bwp == `IMC_BWP_NORMAL || bwp == `IMC_BWP_OSR2 || bwp == `IMC_BWP_OSR4)
			&& output_rate >= `IMC_ODR_MIN && output_rate <= `IMC_ODR_MAX;
	endfunction

	always_comb begin
		n = s;
		// A burst keeps its own pointer after the first byte
		a_eff = (s.acc_burst && acc_req.burst) ? s.acc_ptr : acc_req.addr;
		g_eff = (s.gyr_burst && gyr_req.burst) ? s.gyr_ptr : gyr_req.addr;
		a_off = a_eff - `IMC_ACC_DATA_ADDR;
		g_off = g_eff - `IMC_GYR_DATA_ADDR;
		a_frz = s.acc_burst || (acc_req.rd && acc_req.burst);
		g_frz = s.gyr_burst || (gyr_req.rd && gyr_req.burst);

		// Pin synchronisers
		n.cs_meta = accel_chip_select;
		n.cs_sync = s.cs_meta;
		n.cs_prev = s.cs_sync;
		n.ps_meta = interface_select_pin;
		n.ps_sync = s.ps_meta;

		// Wait for the synchroniser to fill so a pin held high at reset is no edge
		if (!s.ps_taken) begin
			if (s.ps_wait == 2'd2) begin
				n.gyr_spi = s.ps_sync;
				n.ps_taken = 1'b1;
			end else begin
				n.ps_wait = s.ps_wait + 2'd1;
			end
		end else if (s.cs_sync && !s.cs_prev) begin
			n.acc_spi = 1'b1;
		end

		// Accelerometer boot and data capture
		if (s.acc_boot != 20'h00000) begin
			n.acc_boot = s.acc_boot - 20'h00001;
		end
		if (!a_frz) begin
			n.time_img = time_count;
		end
		if (acc_sample.valid && s.acc_en && !a_frz) begin
			n.acc_img = acc_sample.axis;
		end
		if (temp_sample.valid && s.acc_en && !a_frz) begin
			n.tmp_img = temp_sample.value;
		end

		// Accelerometer reads
		n.acc_rvalid = 1'b0;
		if (acc_req.rd) begin
			n.acc_rvalid = 1'b1;
			n.acc_burst = acc_req.burst;
			n.acc_ptr = a_eff + 8'h01;
			if (in_block(a_eff, `IMC_ACC_DATA_ADDR, `IMC_DATA_BYTES)) begin
				n.acc_rdata = data_byte(s.acc_img, s.acc_shadow[2:0], a_off);
				if (!a_off[0]) begin
					n.acc_shadow[a_off[2:1]] = s.acc_img[a_off[2:1]][15:8];
				end
			end else if (a_eff == `IMC_ACC_TEMP_ADDR) begin
				n.acc_rdata = {s.tmp_img[2:0], 5'h00};
				n.acc_shadow[3] = s.tmp_img[10:3];
			end else if (a_eff == `IMC_ACC_TEMP_ADDR + 8'h01) begin
				n.acc_rdata = s.acc_shadow[3];
			end else if (in_block(a_eff, `IMC_ACC_TIME_ADDR, `IMC_TIME_BYTES)) begin
				n.acc_rdata = s.time_img[(a_eff - `IMC_ACC_TIME_ADDR) * 8 +: 8];
			end else if (a_eff == `IMC_ACCEL_CONFIG_ADDR) begin
				n.acc_rdata = s.accel_config;
			end else if (a_eff == `IMC_ACC_PWR_ADDR) begin
				n.acc_rdata = s.acc_pwr;
			end else if (a_eff == `IMC_ACC_ID_ADDR) begin
				n.acc_rdata = ACC_ID;
			end else begin
				n.acc_rdata = 8'h00;
			end
		end else if (!acc_req.burst) begin
			n.acc_burst = 1'b0;
		end

		// Accelerometer writes; a booting part ignores them
		if (acc_req.wr && s.acc_boot == 20'h00000) begin
			if (acc_req.addr == `IMC_ACC_PWR_ADDR) begin
				if (acc_req.wdata == `IMC_ACC_PWR_ON || acc_req.wdata == `IMC_ACC_PWR_OFF) begin
					n.acc_pwr = acc_req.wdata;
				end
			end else if (acc_req.addr == `IMC_ACCEL_CONFIG_ADDR) begin
				if (conf_ok(acc_req.wdata)) begin
					n.accel_config = acc_req.wdata;
				end
			end else if (acc_req.addr == `IMC_ACC_SRST_ADDR && acc_req.wdata == `IMC_SOFT_RESET_CMD) begin
				// Soft reset keeps the interface choice, which only power-on reset clears
				n.acc_pwr = `IMC_ACC_PWR_OFF;
				n.accel_config = `IMC_ACCEL_CONFIG_RST;
				n.acc_img = '0;
				n.tmp_img = '0;
				n.acc_shadow = '0;
				n.acc_boot = 20'(ACC_BOOT_CYCLES);
			end
		end

		// Gyroscope settling and data capture
		if (s.gyr_settle != 20'h00000) begin
			n.gyr_settle = s.gyr_settle - 20'h00001;
		end
		if (gyr_sample.valid && s.gyr_mode == IMC_GYR_NORMAL && !s.gyr_busy && !g_frz) begin
			n.gyr_img = gyr_sample.axis;
		end

		// Gyroscope reads stay available in every mode
		n.gyr_rvalid = 1'b0;
		if (gyr_req.rd) begin
			n.gyr_rvalid = 1'b1;
			n.gyr_burst = gyr_req.burst;
			n.gyr_ptr = g_eff + 8'h01;
			if (in_block(g_eff, `IMC_GYR_DATA_ADDR, `IMC_DATA_BYTES)) begin
				n.gyr_rdata = data_byte(s.gyr_img, s.gyr_shadow, g_off);
				if (!g_off[0]) begin
					n.gyr_shadow[g_off[2:1]] = s.gyr_img[g_off[2:1]][15:8];
				end
			end else if (g_eff == `IMC_GYR_CONF_ADDR) begin
				n.gyr_rdata = s.gyr_conf;
			end else if (g_eff == `IMC_GYR_LPM_ADDR) begin
				case (s.gyr_mode)
					IMC_GYR_SUSPEND: n.gyr_rdata = `IMC_GYR_LPM_SUSPEND;
					IMC_GYR_DEEP: n.gyr_rdata = `IMC_GYR_LPM_DEEP;
					default: n.gyr_rdata = `IMC_GYR_LPM_NORMAL;
				endcase
			end else if (g_eff == `IMC_GYR_ID_ADDR) begin
				n.gyr_rdata = GYR_ID;
			end else begin
				n.gyr_rdata = 8'h00;
			end
		end else if (!gyr_req.burst) begin
			n.gyr_burst = 1'b0;
		end

		// Gyroscope writes and power-mode changes
		if (gyr_req.wr) begin
			if (gyr_req.addr == `IMC_GYR_LPM_ADDR) begin
				case (gyr_req.wdata)
					`IMC_GYR_LPM_NORMAL: begin
						if (s.gyr_mode != IMC_GYR_NORMAL) begin
							n.gyr_mode = IMC_GYR_NORMAL;
							n.gyr_settle = 20'(GYR_SETTLE_CYCLES);
						end
					end
					`IMC_GYR_LPM_SUSPEND: begin
						if (s.gyr_mode != IMC_GYR_SUSPEND) begin
							n.gyr_mode = IMC_GYR_SUSPEND;
							n.gyr_settle = 20'(GYR_SETTLE_CYCLES);
						end
					end
					`IMC_GYR_LPM_DEEP: begin
						if (s.gyr_mode != IMC_GYR_DEEP) begin
							n.gyr_mode = IMC_GYR_DEEP;
							n.gyr_conf = `IMC_GYR_CONF_RST;
							n.gyr_settle = 20'(GYR_SETTLE_CYCLES);
						end
					end
					default: begin
					end
				endcase
			end else if (gyr_req.addr == `IMC_GYR_CONF_ADDR) begin
				n.gyr_conf = gyr_req.wdata;
			end else if (gyr_req.addr == `IMC_GYR_SRST_ADDR && gyr_req.wdata == `IMC_SOFT_RESET_CMD) begin
				n.gyr_mode = IMC_GYR_NORMAL;
				n.gyr_conf = `IMC_GYR_CONF_RST;
				n.gyr_img = '0;
				n.gyr_shadow = '0;
				n.gyr_settle = 20'(GYR_SETTLE_CYCLES);
			end
		end

		// Registered status so every output leaves a flip-flop
		n.acc_en = (n.acc_pwr == `IMC_ACC_PWR_ON) && (n.acc_boot == 20'h00000);
		n.acc_busy = n.acc_boot != 20'h00000;
		n.acc_filt = filt_of(n.accel_config[`IMC_CONF_BWP_MSB:`IMC_CONF_BWP_LSB]);
		n.gyr_busy = n.gyr_settle != 20'h00000;
		n.gyr_on = n.gyr_mode == IMC_GYR_NORMAL;

		// Power-on reset clears everything, interface choice included
		if (!rstn) begin
			n = '0;
			n.accel_config = `IMC_ACCEL_CONFIG_RST;
			n.acc_filt = filt_of(`IMC_BWP_NORMAL);
			n.acc_boot = 20'(ACC_BOOT_CYCLES);
			n.acc_busy = 1'b1;
			n.gyr_mode = IMC_GYR_NORMAL;
			n.gyr_conf = `IMC_GYR_CONF_RST;
			n.gyr_settle = 20'(GYR_SETTLE_CYCLES);
			n.gyr_busy = 1'b1;
			n.gyr_on = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		s <= n;
	end

	assign acc_rdata = s.acc_rdata;
	assign acc_rvalid = s.acc_rvalid;
	assign gyr_rdata = s.gyr_rdata;
	assign gyr_rvalid = s.gyr_rvalid;
	assign accel_spi_mode = s.acc_spi;
	assign gyro_spi_mode = s.gyr_spi;
	assign accel_enable = s.acc_en;
	assign accel_booting = s.acc_busy;
	assign accel_filter = s.acc_filt;
	assign accel_output_rate = s.accel_config[`IMC_CONF_ODR_MSB:`IMC_CONF_ODR_LSB];
	assign sensor_time = s.time_img;
	assign gyro_mode = s.gyr_mode;
	assign gyro_settling = s.gyr_busy;
	assign gyro_analog_on = s.gyr_on;
	assign gyro_config = s.gyr_conf;

endmodule

// ==== tb/imc_host_model.sv ====
// Host controller model driving register accesses into both sensor parts
`timescale 1ns/1ns

module imc_host_model import imc_pkg::*; (
	// Clock
	input wire logic clk,
	// Read answers
	input wire logic [7:0] acc_rdata,
	input wire logic acc_rvalid,
	input wire logic [7:0] gyr_rdata,
	input wire logic gyr_rvalid,
	// Requests
	output imc_req_t acc_req,
	output imc_req_t gyr_req
);
	initial begin
		acc_req = '0;
		gyr_req = '0;
	end

	// One byte per call; burst level is left as given
	task automatic xfer(input logic g, input logic w, input logic [7:0] a, input logic [7:0] d, input logic b,
		output logic [7:0] q);
		imc_req_t r;
		r = '{wr: w, rd: !w, burst: b, addr: a, wdata: d};
		@(posedge clk) #1;
		if (g) gyr_req = r;
		else acc_req = r;
		@(posedge clk) #1;
		// Idle lines carry the inverse so a stale value never passes
		r = '{wr: 1'h0, rd: 1'h0, burst: b, addr: ~a, wdata: ~d};
		if (g) gyr_req = r;
		else acc_req = r;
		q = (g ? gyr_rvalid : acc_rvalid) ? (g ? gyr_rdata : acc_rdata) : 8'hXX;
		if (g && w) begin
			repeat (4) @(posedge clk);
			#1;
		end
	endtask
endmodule

// ==== tb/imc_top_assertions.sv ====
// Port-level checks of the IMU control block
`timescale 1ns/1ns
`include "imc_defines.svh"

module imc_top_assertions import imc_pkg::*; #(
	parameter int GYR_SETTLE_CYCLES = 300000
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Watched inputs
	input wire logic accel_chip_select,
	input wire imc_req_t acc_req,
	input wire imc_req_t gyr_req,
	// Watched outputs
	input wire logic accel_spi_mode,
	input wire logic accel_enable,
	input wire logic accel_booting,
	input wire imc_filter_t accel_filter,
	input wire logic [3:0] accel_output_rate,
	input wire logic [23:0] sensor_time,
	input wire imc_gyro_mode_t gyro_mode,
	input wire logic gyro_settling,
	input wire logic [7:0] gyro_config
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rstn);
	logic [20:0] settle_cnt;
	logic acc_pwr_wr;
	logic gyr_lpm_wr;
	logic quiet;
	assign acc_pwr_wr = acc_req.wr && acc_req.addr == `IMC_ACC_PWR_ADDR;
	assign gyr_lpm_wr = gyr_req.wr && gyr_req.addr == `IMC_GYR_LPM_ADDR;
	assign quiet = !acc_req.burst && !accel_booting;

	// Counter instead of a long repetition
	always_ff @(posedge clk) begin
		if (!rstn || !gyro_settling) begin
			settle_cnt <= '0;
		end else begin
			settle_cnt <= settle_cnt + 21'h1;
		end
	end

	a_spi_sticky: assert property ($past(accel_spi_mode) |-> accel_spi_mode)
		else $error("accel spi mode dropped");
	a_spi_onset: assert property ($rose(accel_chip_select) ##1 accel_chip_select [*3] |-> ##2 accel_spi_mode)
		else $error("chip select edge ignored");
	a_reset_state: assert property ($rose(rstn) |-> gyro_mode == IMC_GYR_NORMAL && !accel_enable && accel_booting)
		else $error("wrong state after reset");
	a_enable_cause: assert property ($rose(accel_enable) |->
		$past(acc_pwr_wr && acc_req.wdata == `IMC_ACC_PWR_ON) && !accel_booting)
		else $error("accel enabled without power write");
	a_gyro_suspend: assert property (gyr_lpm_wr && gyr_req.wdata == 8'h80 |=> gyro_mode == IMC_GYR_SUSPEND)
		else $error("gyro suspend not entered");
	a_gyro_deep: assert property (gyr_lpm_wr && gyr_req.wdata == 8'h20 |=>
		gyro_mode == IMC_GYR_DEEP && gyro_config == 8'h00)
		else $error("gyro deep suspend wrong");
	a_settle_bound: assert property (settle_cnt <= GYR_SETTLE_CYCLES + 2)
		else $error("gyro settle too long");
	a_burst_freeze: assert property (acc_req.burst && $past(acc_req.burst) && $past(acc_req.burst, 2) |->
		$stable(sensor_time))
		else $error("time moved during burst");
	a_time_step: assert property (quiet && $past(quiet) && $past(quiet, 2) && $past(quiet, 3) && $changed(sensor_time) |->
		sensor_time == $past(sensor_time) + 24'h1)
		else $error("time counter jumped");
	a_filter_map: assert property (acc_req.wr && acc_req.addr == `IMC_ACCEL_CONFIG_ADDR && acc_req.wdata[7:4] == 4'h8 &&
		acc_req.wdata[3:0] inside {[4'h5:4'hC]} && !accel_booting |=>
		accel_filter == IMC_FILT_OSR4 && accel_output_rate == $past(acc_req.wdata[3:0]))
		else $error("config field not applied");
endmodule

// ==== tb/imc_top_tb.sv ====
// Self-checking bench of the IMU control block
`timescale 1ns/1ns
`include "imc_defines.svh"

module imc_top_tb import imc_pkg::*; ;
	localparam int BOOT = 20;
	localparam int SETTLE = 50;
	logic clk, rstn, interface_select_pin, accel_chip_select;
	imc_req_t acc_req, gyr_req;
	logic [7:0] acc_rdata, gyr_rdata, gyro_config;
	logic acc_rvalid, gyr_rvalid, accel_spi_mode, gyro_spi_mode, accel_enable, accel_booting;
	logic gyro_settling, gyro_analog_on;
	imc_sample_t acc_sample, gyr_sample;
	imc_temp_t temp_sample;
	imc_filter_t accel_filter;
	logic [3:0] accel_output_rate;
	logic [23:0] sensor_time, t0;
	imc_gyro_mode_t gyro_mode;
	logic [16:0] ctl;
	logic [33:0] rows [0:13];
	logic [47:0] q, r;
	int failures, checks_done;
	assign ctl = {accel_enable, accel_filter, accel_output_rate, gyro_mode, gyro_config};

	imc_top #(.ACC_BOOT_CYCLES(BOOT), .GYR_SETTLE_CYCLES(SETTLE)) i_dut (.clk, .rstn, .interface_select_pin,
		.accel_chip_select, .acc_req, .acc_rdata, .acc_rvalid, .gyr_req, .gyr_rdata, .gyr_rvalid, .acc_sample,
		.temp_sample, .gyr_sample, .accel_spi_mode, .gyro_spi_mode, .accel_enable, .accel_booting, .accel_filter,
		.accel_output_rate, .sensor_time, .gyro_mode, .gyro_settling, .gyro_analog_on, .gyro_config);
	imc_host_model h (.clk, .acc_rdata, .acc_rvalid, .gyr_rdata, .gyr_rvalid, .acc_req, .gyr_req);

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("failures %0d checks_done %0d", failures, checks_done);
		if (failures == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wait_low(input logic gyro, input int lim);
		int n;
		n = 0;
		while ((gyro ? gyro_settling : accel_booting) !== 1'h0 && n < lim) begin
			cyc(1);
			n++;
		end
		if (n >= lim) begin
			failures++;
			stop_test();
		end
	endtask

	task automatic rd(input logic g, input logic [7:0] a, input int n, output logic [47:0] v);
		v = '0;
		for (int i = 0; i < n; i++) begin
			h.xfer(g, 1'h0, a + 8'(i), 8'h00, i < n - 1, v[8*i +: 8]);
		end
	endtask

	task automatic wr(input logic g, input logic [7:0] a, input logic [7:0] d);
		logic [7:0] b;
		h.xfer(g, 1'h1, a, d, 1'h0, b);
	endtask

	task automatic pulse(input int k, input logic [47:0] v);
		@(posedge clk) #1;
		acc_sample = '{valid: k == 0, axis: v};
		gyr_sample = '{valid: k == 1, axis: v};
		temp_sample = '{valid: k == 2, value: v[10:0]};
		cyc(1);
		acc_sample.valid = 1'h0;
		gyr_sample.valid = 1'h0;
		temp_sample.valid = 1'h0;
	endtask

	task automatic do_reset();
		@(posedge clk) #1;
		rstn = 1'h0;
		cyc(8);
		rstn = 1'h1;
	endtask

	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end

	initial begin
		failures = 0;
		checks_done = 0;
		rstn = 1'h0;
		interface_select_pin = 1'h1;
		accel_chip_select = 1'h0;
		acc_sample = '0;
		gyr_sample = '0;
		temp_sample = '0;
		rows = '{{1'h0, 8'h7D, 8'h04, 17'h12000}, {1'h0, 8'h40, 8'h98, 17'h16000}, {1'h0, 8'h40, 8'h85, 17'h19400},
			{1'h0, 8'h40, 8'hAC, 17'h13000}, {1'h0, 8'h40, 8'hB7, 17'h13000}, {1'h0, 8'h40, 8'hA4, 17'h13000},
			{1'h0, 8'h7D, 8'h02, 17'h13000}, {1'h0, 8'h7D, 8'h00, 17'h03000}, {1'h1, 8'h0F, 8'h07, 17'h03007},
			{1'h1, 8'h11, 8'h80, 17'h03107}, {1'h1, 8'h11, 8'h00, 17'h03007}, {1'h1, 8'h11, 8'h20, 17'h03200},
			{1'h1, 8'h11, 8'h00, 17'h03000}, {1'h0, 8'h7D, 8'h04, 17'h13000}};
		do_reset();
		chk({accel_booting, accel_enable, accel_filter, accel_output_rate, gyro_mode}, 10'h220);
		wr(1'h0, `IMC_ACC_PWR_ADDR, `IMC_ACC_PWR_ON);
		cyc(2);
		chk(accel_enable, 1'h0);
		// Chip select toggles as an 800 ns link clock during frames only
		repeat (3) begin
			accel_chip_select = 1'h1;
			cyc(4);
			accel_chip_select = 1'h0;
			cyc(4);
		end
		chk(accel_spi_mode, 1'h1);
		rd(1'h0, `IMC_ACC_ID_ADDR, 1, q);
		wait_low(1'h0, BOOT + 4);
		chk(gyro_spi_mode, 1'h1);
		wait_low(1'h1, SETTLE + 4);
		foreach (rows[i]) begin
			wr(rows[i][33], rows[i][32:25], rows[i][24:17]);
			cyc(2);
			chk(ctl, rows[i][16:0]);
			wait_low(1'h1, SETTLE + 4);
		end
		pulse(0, 48'h5566_3344_1122);
		rd(1'h0, `IMC_ACC_DATA_ADDR, 6, q);
		chk(q, 48'h5566_3344_1122);
		pulse(0, 48'h0000_0000_AABB);
		rd(1'h0, `IMC_ACC_DATA_ADDR, 1, r);
		pulse(0, 48'h0000_0000_CCDD);
		rd(1'h0, `IMC_ACC_DATA_ADDR + 8'h01, 1, q);
		chk({q[7:0], r[7:0]}, 16'hAABB);
		h.xfer(1'h0, 1'h0, `IMC_ACC_DATA_ADDR + 8'h01, 8'h00, 1'h1, r[7:0]);
		pulse(0, 48'h0000_7777_EEFF);
		h.xfer(1'h0, 1'h0, `IMC_ACC_DATA_ADDR + 8'h02, 8'h00, 1'h0, q[7:0]);
		chk(q[7:0], 8'h00);
		pulse(2, 48'h5A3);
		rd(1'h0, `IMC_ACC_TEMP_ADDR, 2, q);
		chk(q[15:0], 16'hB460);
		rd(1'h0, `IMC_ACC_TIME_ADDR, 3, q);
		chk(sensor_time, q[23:0]);
		t0 = q[23:0];
		cyc(3906);
		rd(1'h0, `IMC_ACC_TIME_ADDR, 3, q);
		t0 = q[23:0] - t0;
		chk(t0 >= 24'h9 && t0 <= 24'hB, 1'h1);
		wr(1'h0, `IMC_ACC_PWR_ADDR, `IMC_ACC_PWR_OFF);
		pulse(2, 48'h7FF);
		rd(1'h0, `IMC_ACC_TEMP_ADDR, 2, q);
		chk(q[15:0], 16'hB460);
		pulse(1, 48'h0102_0304_0506);
		wr(1'h1, `IMC_GYR_LPM_ADDR, `IMC_GYR_LPM_SUSPEND);
		wait_low(1'h1, SETTLE + 4);
		chk(gyro_analog_on, 1'h0);
		pulse(1, 48'h0);
		rd(1'h1, `IMC_GYR_DATA_ADDR, 6, q);
		chk(q, 48'h0102_0304_0506);
		wr(1'h1, `IMC_GYR_SRST_ADDR, `IMC_SOFT_RESET_CMD);
		cyc(2);
		chk(gyro_mode, IMC_GYR_NORMAL);
		chk(gyro_analog_on, 1'h1);
		wr(1'h0, `IMC_ACC_SRST_ADDR, `IMC_SOFT_RESET_CMD);
		cyc(2);
		chk({accel_booting, accel_spi_mode, accel_output_rate}, 6'h38);
		interface_select_pin = 1'h0;
		do_reset();
		cyc(4);
		chk({gyro_spi_mode, accel_spi_mode}, 2'h0);
		stop_test();
	end
endmodule

bind imc_top imc_top_assertions #(.GYR_SETTLE_CYCLES(GYR_SETTLE_CYCLES)) i_chk (.clk, .rstn, .accel_chip_select,
	.acc_req, .gyr_req, .accel_spi_mode, .accel_enable, .accel_booting, .accel_filter, .accel_output_rate,
	.sensor_time, .gyro_mode, .gyro_settling, .gyro_config);
